// [dv/asalu_core_props.sv]
// port assertions for the add/shift datapath
// assumes one clock domain, bound onto asalu_core
`timescale 1ns/1ps
`default_nettype none
module asalu_core_props (
  input wire logic                 core_clk,
  input wire logic                 arst_n,
  input wire logic                 op_valid,
  input wire asalu_pkg::asalu_op_t op_code,
  input wire logic [7:0]           op_lit,
  input wire logic                 op_dest,
  input wire logic                 op_indirect,
  input wire logic [7:0]           file_rdata,
  input wire logic                 op_busy_q,
  input wire logic                 op_done_q,
  input wire logic                 file_we_q,
  input wire logic [7:0]           acc_q,
  input wire logic                 carry_q,
  input wire logic                 nibble_spill_bit_q,
  input wire logic                 zero_q
);
  import asalu_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // indirect ops may stall, so only plain ones are timed here
  logic go;
  logic mem;
  assign go  = op_valid & ~op_busy_q & ~op_indirect;
  assign mem = op_code inside {and_mem_op, add_mem_op,
                               arith_shift_right_op, add_with_spill_op};

  AST_PTR_FLAGS: assert property (go && op_code == pointer_offset_op |=>
    $stable(carry_q) && $stable(zero_q) && $stable(acc_q))
    else $error("pointer offset disturbed acc or flags");
  AST_AND_IMM: assert property (go && op_code == and_immediate_op |=>
    acc_q == ($past(acc_q) & $past(op_lit)) && $stable(carry_q))
    else $error("and immediate result wrong");
  AST_ADD_IMM: assert property (go && op_code == add_immediate_op |=>
    {carry_q, acc_q} == {1'b0, $past(acc_q)} + $past(op_lit) &&
    nibble_spill_bit_q == (({1'b0, $past(acc_q[3:0])} +
                            $past(op_lit[3:0])) > 5'h0f))
    else $error("add immediate sum or flags wrong");
  AST_WB: assert property (go && op_dest && mem |=>
    file_we_q && $stable(acc_q))
    else $error("file target not written");
  AST_NO_WB: assert property (go && !op_dest |=> !file_we_q)
    else $error("file written for acc target");
  AST_AND_MEM: assert property (go && !op_dest && op_code == and_mem_op |=>
    acc_q == ($past(acc_q) & $past(file_rdata)) && $stable(carry_q))
    else $error("and mem result wrong");
  AST_ADD_MEM: assert property (go && !op_dest && op_code == add_mem_op |=>
    {carry_q, acc_q} == {1'b0, $past(acc_q)} + $past(file_rdata))
    else $error("add mem sum wrong");
  AST_ASR: assert property (go && op_code == arith_shift_right_op |=>
    carry_q == $past(file_rdata[0]) &&
    zero_q == ($past(file_rdata[7:1]) == 7'h00))
    else $error("shift carry or zero wrong");
  AST_SPILL: assert property (go && !op_dest && op_code == add_with_spill_op |=>
    {carry_q, acc_q} ==
    {1'b0, $past(acc_q)} + $past(file_rdata) + $past(carry_q))
    else $error("add with spill sum wrong");
  AST_STALL: assert property (op_busy_q |=> !op_busy_q && op_done_q)
    else $error("stall longer than one cycle");
  AST_ZERO: assert property (go && op_code inside {and_immediate_op,
    add_immediate_op} |=> zero_q == (acc_q == 8'h00))
    else $error("zero flag wrong");

  cover property (op_busy_q);
  cover property (file_we_q);
  cover property (go && op_code == add_with_spill_op && carry_q);
endmodule : asalu_core_props

bind asalu_core asalu_core_props asalu_core_props_i (.*);
`default_nettype wire

// [dv/test_asalu_core.sv]
// self-checking bench for the add/shift datapath core
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
`default_nettype none
`include "asalu_params.svh"
module test_asalu_core;
  import asalu_pkg::*;
  logic       core_clk, arst_n, op_valid, op_ptr_sel, op_dest, op_indirect;
  logic       op_ind_sel, reg_wr, reg_rd, file_we_q, op_busy_q, op_done_q;
  logic       carry_q, nibble_spill_bit_q, zero_q, m_c, m_dc, m_z;
  asalu_op_t  op_code;
  logic [7:0] op_lit, file_rdata, reg_wdata, reg_rdata_q, file_wdata_q;
  logic [7:0] acc_q, m_acc;
  logic [6:0] op_faddr, file_waddr_q;
  logic [3:0] reg_addr;
  int         errors, n_checks;

  asalu_core asalu_core_i (
    .core_clk           (core_clk),
    .arst_n             (arst_n),
    .op_valid           (op_valid),
    .op_code            (op_code),
    .op_lit             (op_lit),
    .op_ptr_sel         (op_ptr_sel),
    .op_dest            (op_dest),
    .op_faddr           (op_faddr),
    .op_indirect        (op_indirect),
    .op_ind_sel         (op_ind_sel),
    .file_rdata         (file_rdata),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata_q        (reg_rdata_q),
    .op_busy_q          (op_busy_q),
    .op_done_q          (op_done_q),
    .file_we_q          (file_we_q),
    .file_waddr_q       (file_waddr_q),
    .file_wdata_q       (file_wdata_q),
    .acc_q              (acc_q),
    .carry_q            (carry_q),
    .nibble_spill_bit_q (nibble_spill_bit_q),
    .zero_q             (zero_q)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk("reg read", exp, reg_rdata_q);
  endtask : rd

  // operand held after the request so a stalled op re-reads the same value
  task automatic run(asalu_op_t c, logic [7:0] b, logic d, logic s,
                     logic ind, logic st);
    @(posedge core_clk);
    op_valid    <= 1'b1;
    op_code     <= c;
    op_lit      <= b;
    file_rdata  <= b;
    op_faddr    <= b[6:0];
    op_dest     <= d;
    op_ptr_sel  <= s;
    op_ind_sel  <= s;
    op_indirect <= ind;
    @(posedge core_clk);
    op_valid    <= 1'b0;
    #1;
    chk("busy", st, op_busy_q);
    if (st) begin
      @(posedge core_clk);
      #1;
    end
    chk("done", 1'b1, op_done_q);
    chk("file write", d, file_we_q);
  endtask : run

  task automatic op(asalu_op_t c, logic [7:0] b, logic d, logic ind, logic st);
    logic       ci;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    ci = (c == add_with_spill_op) & m_c;
    s  = {1'b0, m_acc} + b + ci;
    h  = {1'b0, m_acc[3:0]} + b[3:0] + ci;
    r  = s[7:0];
    if (c inside {and_immediate_op, and_mem_op})
      r = m_acc & b;
    if (c == arith_shift_right_op)
      r = {b[7], b[7:1]};
    if (c inside {add_immediate_op, add_mem_op, add_with_spill_op}) begin
      m_c  = s[8];
      m_dc = h[4];
    end
    if (c == arith_shift_right_op)
      m_c = b[0];
    m_z = (r == 8'h00);
    run(c, b, d, 1'b1, ind, st);
    if (d) begin
      chk("write data", r, file_wdata_q);
      chk("write addr", b[6:0], file_waddr_q);
    end else
      m_acc = r;
    chk("acc", m_acc, acc_q);
    chk("flags", {m_c, m_dc, m_z}, {carry_q, nibble_spill_bit_q, zero_q});
  endtask : op

  task automatic t_reset;
    rd(`ASALU_OFF_ACC, 8'h00);
    rd(`ASALU_OFF_STATUS, 8'h00);
    rd(`ASALU_OFF_PTR1_HI, 8'h00);
    rd(`ASALU_OFF_CTRL, 8'h01);
    // read data stand for one cycle only
    @(posedge core_clk);
    #1;
    chk("read idle", 8'h00, reg_rdata_q);
    wr(4'hf, 8'h5a);
    rd(4'hf, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_imm;
    wr(`ASALU_OFF_ACC, 8'h0f);
    m_acc = 8'h0f;
    op(add_immediate_op, 8'hf1, 1'b0, 1'b0, 1'b0);
    op(and_immediate_op, 8'hfe, 1'b0, 1'b0, 1'b0);
    op(add_immediate_op, 8'h08, 1'b0, 1'b0, 1'b0);
    op(add_immediate_op, 8'h08, 1'b0, 1'b0, 1'b0);
    op(and_immediate_op, 8'hff, 1'b0, 1'b0, 1'b0);
    $display("immediate test done");
  endtask : t_imm

  task automatic t_mem;
    asalu_op_t  m[4] = '{and_mem_op, add_mem_op, arith_shift_right_op,
                         add_with_spill_op};
    logic [7:0] v[8] = '{8'hf0, 8'h88, 8'h81, 8'h7f,
                         8'h00, 8'hff, 8'h01, 8'h80};
    for (int i = 0; i < 8; i++) begin
      op(m[i % 4], v[i], i >= 4, 1'b0, 1'b0);
    end
    $display("file operand test done");
  endtask : t_mem

  task automatic t_ptr;
    wr(`ASALU_OFF_PTR0_LO, 8'hff);
    wr(`ASALU_OFF_PTR0_HI, 8'hff);
    run(pointer_offset_op, 8'hc1, 1'b0, 1'b0, 1'b0, 1'b0);
    run(pointer_offset_op, 8'h1f, 1'b0, 1'b0, 1'b0, 1'b0);
    run(pointer_offset_op, 8'h20, 1'b0, 1'b1, 1'b0, 1'b0);
    rd(`ASALU_OFF_PTR0_LO, 8'h1f);
    rd(`ASALU_OFF_PTR0_HI, 8'h00);
    rd(`ASALU_OFF_PTR1_LO, 8'he0);
    rd(`ASALU_OFF_PTR1_HI, 8'hff);
    chk("flags", {m_c, m_dc, m_z}, {carry_q, nibble_spill_bit_q, zero_q});
    $display("pointer test done");
  endtask : t_ptr

  // pointer pair 1 now has its top bit set
  task automatic t_stall;
    op(add_mem_op, 8'h11, 1'b1, 1'b1, 1'b1);
    wr(`ASALU_OFF_CTRL, 8'h00);
    op(add_mem_op, 8'h22, 1'b0, 1'b1, 1'b0);
    $display("stall test done");
  endtask : t_stall

  // acc and pointer 1 hold non-reset values when reset hits
  task automatic t_mid_reset;
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("reset acc", 8'h00, acc_q);
    chk("reset flags", 3'b000, {carry_q, nibble_spill_bit_q, zero_q});
    chk("reset done", 1'b0, op_done_q);
    @(posedge core_clk);
    arst_n <= 1'b1;
    {m_acc, m_c, m_dc, m_z} = '0;
    rd(`ASALU_OFF_PTR1_HI, 8'h00);
    rd(`ASALU_OFF_CTRL, 8'h01);
    op(add_immediate_op, 8'h00, 1'b0, 1'b0, 1'b0);
    $display("mid-run reset test done");
  endtask : t_mid_reset

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  initial begin
    arst_n = 1'b0;
    {op_valid, op_ptr_sel, op_dest, op_indirect, op_ind_sel} = '0;
    {reg_wr, reg_rd, op_lit, file_rdata, reg_wdata, op_faddr, reg_addr} = '0;
    op_code = op_none;
    {m_acc, m_c, m_dc, m_z} = '0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset;
    t_imm;
    t_mem;
    t_ptr;
    t_stall;
    t_mid_reset;
    stop_test;
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    errors++;
    $display("mismatch watchdog expected done seen timeout");
    stop_test;
  end
endmodule : test_asalu_core
`default_nettype wire

// [hw/asalu_core.sv]
// add/shift datapath: accumulator, status flags, two pointer pairs
// assumes the file register array lives outside and supplies the operand
//
// Function
// - pointer offset adds sign-extended 6-bit literal to chosen pair, flags untouched
// - pointer pair result wraps modulo 16 bits, no flag raised
// - and-immediate ANDs accumulator with literal into accumulator, zero only
// - add-immediate adds literal to accumulator, updates carry, nibble, zero
// - target bit 0 sends a file-operand op result to accumulator, 1 to file register
// - and-mem ANDs accumulator with file register, to target, zero only
// - add-mem adds accumulator and file register, updates carry, nibble, zero
// - shift right keeps bit 7, bit 0 into carry, updates carry, zero
// - add-with-spill adds accumulator, file register and carry, all three flags
// - indirect access with pointer top bit set costs one extra cycle
`timescale 1ns/1ps
`default_nettype none
`include "asalu_params.svh"
module asalu_core (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 op_valid,
  input  wire asalu_pkg::asalu_op_t op_code,
  input  wire logic [7:0]           op_lit,
  input  wire logic                 op_ptr_sel,
  input  wire logic                 op_dest,
  input  wire logic [6:0]           op_faddr,
  input  wire logic                 op_indirect,
  input  wire logic                 op_ind_sel,
  input  wire logic [7:0]           file_rdata,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata_q,
  output logic                      op_busy_q,
  output logic                      op_done_q,
  output logic                      file_we_q,
  output logic [6:0]                file_waddr_q,
  output logic [7:0]                file_wdata_q,
  output logic [7:0]                acc_q,
  output logic                      carry_q,
  output logic                      nibble_spill_bit_q,
  output logic                      zero_q
);
  import asalu_pkg::*;

  asalu_exec_if ex ();

  asalu_exec u_exec (
    .x (ex)
  );

  asalu_state_t state_q, state_d;
  asalu_op_t    hop_q, hop_d;
  logic [7:0]   hlit_q, hlit_d;
  logic         hptr_q, hptr_d;
  logic         hdest_q, hdest_d;
  logic [6:0]   hfaddr_q, hfaddr_d;
  logic [15:0]  ptr_q [2];
  logic [15:0]  ptr_d [2];
  logic [7:0]   acc_d;
  logic         carry_d, nibble_d, zero_d;
  logic         stall_en_q, stall_en_d;
  logic         busy_d, done_d, fwe_d;
  logic [6:0]   fwaddr_d;
  logic [7:0]   fwdata_d, rdata_d;
  logic         exec_now;
  logic         ptr_sel_now, dest_now;
  logic [6:0]   faddr_now;
  logic         need_stall;

  // indirect operand through a pointer whose top bit is set;
  // an empty request never stalls, it would end with no done pulse
  assign need_stall = op_valid && op_indirect && stall_en_q &&
                      (op_code != op_none) &&
                      ptr_q[op_ind_sel][`ASALU_PTR_TOP];

  always_comb begin
    state_d  = state_q;
    hop_d    = hop_q;
    hlit_d   = hlit_q;
    hptr_d   = hptr_q;
    hdest_d  = hdest_q;
    hfaddr_d = hfaddr_q;
    exec_now = 1'b0;
    ex.op    = op_none;
    ex.lit   = op_lit;
    ptr_sel_now = op_ptr_sel;
    dest_now    = op_dest;
    faddr_now   = op_faddr;
    case (state_q)
      st_run: begin
        if (need_stall) begin
          // hold the operation; it runs during the extra cycle, in st_stall
          state_d  = st_stall;
          hop_d    = op_code;
          hlit_d   = op_lit;
          hptr_d   = op_ptr_sel;
          hdest_d  = op_dest;
          hfaddr_d = op_faddr;
        end else if (op_valid) begin
          exec_now = 1'b1;
          ex.op    = op_code;
        end
      end
      st_stall: begin
        state_d     = st_run;
        exec_now    = 1'b1;
        ex.op       = hop_q;
        ex.lit      = hlit_q;
        ptr_sel_now = hptr_q;
        dest_now    = hdest_q;
        faddr_now   = hfaddr_q;
      end
      default: begin
        state_d = st_run;
      end
    endcase
    busy_d = (state_d == st_stall);
  end

  assign ex.acc      = acc_q;
  assign ex.fval     = file_rdata;
  assign ex.carry_in = carry_q;
  assign ex.ptr      = ptr_q[ptr_sel_now];

  // software writes lose to an executing operation in the same cycle
  always_comb begin
    acc_d      = acc_q;
    carry_d    = carry_q;
    nibble_d   = nibble_spill_bit_q;
    zero_d     = zero_q;
    ptr_d[0]   = ptr_q[0];
    ptr_d[1]   = ptr_q[1];
    stall_en_d = stall_en_q;
    fwe_d      = 1'b0;
    fwaddr_d   = file_waddr_q;
    fwdata_d   = file_wdata_q;
    rdata_d    = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `ASALU_OFF_ACC:     acc_d = reg_wdata;
        `ASALU_OFF_STATUS: begin
          carry_d  = reg_wdata[`ASALU_BIT_CARRY];
          nibble_d = reg_wdata[`ASALU_BIT_NIBBLE];
          zero_d   = reg_wdata[`ASALU_BIT_ZERO];
        end
        `ASALU_OFF_PTR0_LO: ptr_d[0][7:0]  = reg_wdata;
        `ASALU_OFF_PTR0_HI: ptr_d[0][15:8] = reg_wdata;
        `ASALU_OFF_PTR1_LO: ptr_d[1][7:0]  = reg_wdata;
        `ASALU_OFF_PTR1_HI: ptr_d[1][15:8] = reg_wdata;
        `ASALU_OFF_CTRL:    stall_en_d = reg_wdata[`ASALU_BIT_STALL_EN];
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
    if (exec_now) begin
      if (ex.op == pointer_offset_op) begin
        ptr_d[ptr_sel_now] = ex.ptr_res;
      end else if (ex.op == and_immediate_op ||
                   ex.op == add_immediate_op) begin
        acc_d = ex.result;
      end else if (ex.op != op_none) begin
        if (dest_now) begin
          fwe_d    = 1'b1;
          fwaddr_d = faddr_now;
          fwdata_d = ex.result;
        end else begin
          acc_d = ex.result;
        end
      end
      if (ex.carry_we) carry_d = ex.carry;
      if (ex.nibble_we) nibble_d = ex.nibble;
      if (ex.zero_we) zero_d = ex.zero;
    end
    if (reg_rd) begin
      case (reg_addr)
        `ASALU_OFF_ACC:     rdata_d = acc_q;
        `ASALU_OFF_STATUS: begin
          rdata_d[`ASALU_BIT_CARRY]  = carry_q;
          rdata_d[`ASALU_BIT_NIBBLE] = nibble_spill_bit_q;
          rdata_d[`ASALU_BIT_ZERO]   = zero_q;
          rdata_d[`ASALU_BIT_BUSY]   = op_busy_q;
        end
        `ASALU_OFF_PTR0_LO: rdata_d = ptr_q[0][7:0];
        `ASALU_OFF_PTR0_HI: rdata_d = ptr_q[0][15:8];
        `ASALU_OFF_PTR1_LO: rdata_d = ptr_q[1][7:0];
        `ASALU_OFF_PTR1_HI: rdata_d = ptr_q[1][15:8];
        `ASALU_OFF_CTRL:    rdata_d = {7'h00, stall_en_q};
        default:            rdata_d = 8'h00;
      endcase
    end
    done_d = exec_now && (ex.op != op_none);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q            <= st_run;
      hop_q              <= op_none;
      hlit_q             <= 8'h00;
      hptr_q             <= 1'b0;
      hdest_q            <= 1'b0;
      hfaddr_q           <= 7'h00;
      ptr_q[0]           <= `ASALU_RST_PTR;
      ptr_q[1]           <= `ASALU_RST_PTR;
      acc_q              <= `ASALU_RST_ACC;
      carry_q            <= 1'b0;
      nibble_spill_bit_q <= 1'b0;
      zero_q             <= 1'b0;
      stall_en_q         <= 1'b1;
      op_busy_q          <= 1'b0;
      op_done_q          <= 1'b0;
      file_we_q          <= 1'b0;
      file_waddr_q       <= 7'h00;
      file_wdata_q       <= 8'h00;
      reg_rdata_q        <= 8'h00;
    end else begin
      state_q            <= state_d;
      hop_q              <= hop_d;
      hlit_q             <= hlit_d;
      hptr_q             <= hptr_d;
      hdest_q            <= hdest_d;
      hfaddr_q           <= hfaddr_d;
      ptr_q[0]           <= ptr_d[0];
      ptr_q[1]           <= ptr_d[1];
      acc_q              <= acc_d;
      carry_q            <= carry_d;
      nibble_spill_bit_q <= nibble_d;
      zero_q             <= zero_d;
      stall_en_q         <= stall_en_d;
      op_busy_q          <= busy_d;
      op_done_q          <= done_d;
      file_we_q          <= fwe_d;
      file_waddr_q       <= fwaddr_d;
      file_wdata_q       <= fwdata_d;
      reg_rdata_q        <= rdata_d;
    end
  end
endmodule : asalu_core
`default_nettype wire

// [hw/asalu_exec.sv]
// combinational arithmetic unit: results and flag updates per operation
// assumes operands are stable for the whole cycle
`timescale 1ns/1ps
`default_nettype none
module asalu_exec (
  asalu_exec_if.alu x
);
  import asalu_pkg::*;

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic       cin;

  always_comb begin
    addend = (x.op == add_immediate_op) ? x.lit : x.fval;
    cin    = (x.op == add_with_spill_op) ? x.carry_in : 1'b0;
    sum     = {1'b0, x.acc} + {1'b0, addend} + {8'h00, cin};
    low_sum = {1'b0, x.acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    x.result    = 8'h00;
    x.ptr_res   = x.ptr;
    x.carry     = x.carry_in;
    x.nibble    = low_sum[4];
    x.carry_we  = 1'b0;
    x.nibble_we = 1'b0;
    x.zero_we   = 1'b0;
    case (x.op)
      pointer_offset_op: begin
        // 16-bit add drops the carry out, so both ends wrap
        x.ptr_res = x.ptr + {{10{x.lit[5]}}, x.lit[5:0]};
      end
      and_immediate_op: begin
        x.result  = x.acc & x.lit;
        x.zero_we = 1'b1;
      end
      and_mem_op: begin
        x.result  = x.acc & x.fval;
        x.zero_we = 1'b1;
      end
      add_immediate_op, add_mem_op, add_with_spill_op: begin
        x.result    = sum[7:0];
        x.carry     = sum[8];
        x.carry_we  = 1'b1;
        x.nibble_we = 1'b1;
        x.zero_we   = 1'b1;
      end
      arith_shift_right_op: begin
        x.result   = {x.fval[7], x.fval[7:1]};
        x.carry    = x.fval[0];
        x.carry_we = 1'b1;
        x.zero_we  = 1'b1;
      end
      default: begin
        x.result = 8'h00;
      end
    endcase
    x.zero = (x.result == 8'h00);
  end
endmodule : asalu_exec
`default_nettype wire

// [hw/asalu_exec_if.sv]
// operand and result bundle between the core and its arithmetic unit
// assumes both ends are in one clock domain
`timescale 1ns/1ps
`default_nettype none
interface asalu_exec_if;
  asalu_pkg::asalu_op_t op;
  logic [7:0]           acc;
  logic [7:0]           fval;
  logic [7:0]           lit;
  logic                 carry_in;
  logic [15:0]          ptr;
  logic [7:0]           result;
  logic [15:0]          ptr_res;
  logic                 carry;
  logic                 nibble;
  logic                 zero;
  logic                 carry_we;
  logic                 nibble_we;
  logic                 zero_we;

  modport core (output op, acc, fval, lit, carry_in, ptr,
                input result, ptr_res, carry, nibble, zero,
                carry_we, nibble_we, zero_we);
  modport alu (input op, acc, fval, lit, carry_in, ptr,
               output result, ptr_res, carry, nibble, zero,
               carry_we, nibble_we, zero_we);
endinterface : asalu_exec_if
`default_nettype wire

// [hw/asalu_params.svh]
// offsets, field positions and reset values of the add/shift datapath
// assumes inclusion by bare name from the bench and the core
`ifndef ASALU_PARAMS_SVH
`define ASALU_PARAMS_SVH

`define ASALU_ADDR_W      4
`define ASALU_OFF_ACC     4'h0
`define ASALU_OFF_STATUS  4'h1
`define ASALU_OFF_PTR0_LO 4'h2
`define ASALU_OFF_PTR0_HI 4'h3
`define ASALU_OFF_PTR1_LO 4'h4
`define ASALU_OFF_PTR1_HI 4'h5
`define ASALU_OFF_CTRL    4'h6

`define ASALU_BIT_CARRY   0
`define ASALU_BIT_NIBBLE  1
`define ASALU_BIT_ZERO    2
`define ASALU_BIT_BUSY    3

`define ASALU_BIT_STALL_EN 0

`define ASALU_RST_ACC     8'h00
`define ASALU_RST_PTR     16'h0000
`define ASALU_RST_CTRL    8'h01
`define ASALU_PTR_TOP     15

`endif

// [hw/asalu_pkg.sv]
// types shared by the add/shift datapath modules
// assumes the params header sits beside it
package asalu_pkg;
  typedef enum logic [2:0] {
    op_none,
    pointer_offset_op,
    and_immediate_op,
    add_immediate_op,
    and_mem_op,
    add_mem_op,
    arith_shift_right_op,
    add_with_spill_op
  } asalu_op_t;

  typedef enum logic {
    st_run,
    st_stall
  } asalu_state_t;
endpackage : asalu_pkg
